/* src/mpbi_pkg.sv */
package mpbi_pkg;

    // Pin bundle as seen at the device balls, one bit per control pin
    typedef struct packed {
        logic ceN;
        logic addrValidN;
        logic oeN;
        logic weN;
        logic lowByteEnN;
        logic highByteEnN;
        logic cfgRegSelect;
        logic memClk;
        logic [5:0] addrHigh;
        logic [15:0] dq;
    } mpbi_pins_s;

    // Deselected bus: selects and strobes high, select and clock low
    localparam mpbi_pins_s PINS_IDLE = mpbi_pins_s'(30'h3F000000);

    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int ROW_BITS = 7;
    localparam logic [ROW_BITS-1:0] ROW_START = 7'h00;
    localparam logic [3:0] ROW_REOPEN_CYCLES = 4'h2;

    // Power-up self initialization time, converted to clk cycles (rounded up)
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWERUP_INIT_TIME_NS = 150000;
    localparam int INIT_CYCLES = (POWERUP_INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);

    // Bus configuration register fields
    localparam int BCR_MODE_BIT = 15;
    localparam int BCR_FIXED_LAT_BIT = 14;
    localparam int BCR_LAT_HI = 13;
    localparam int BCR_LAT_LO = 11;
    localparam int BCR_WRAP_BIT = 3;
    localparam int BCR_LEN_HI = 2;
    localparam int BCR_LEN_LO = 0;
    localparam logic [15:0] BCR_RESET = 16'h9807;

    // Refresh configuration register
    localparam int RCR_DPD_BIT = 4;
    localparam logic [15:0] RCR_RESET = 16'h0010;

    // Register select field of the latched address
    localparam int REG_SEL_HI = 19;
    localparam int REG_SEL_LO = 18;
    localparam logic [1:0] REG_SEL_BCR = 2'h2;
    localparam logic [1:0] REG_SEL_RCR = 2'h0;
    localparam logic [1:0] REG_SEL_IDENT = 2'h1;

    // Burst length codes
    localparam logic [2:0] LEN_4 = 3'h1;
    localparam logic [2:0] LEN_8 = 3'h2;
    localparam logic [2:0] LEN_16 = 3'h3;
    localparam logic [2:0] LEN_32 = 3'h4;

    typedef enum {
        ST_INIT, ST_STANDBY, ST_DPD, ST_ACTIVE, ST_LATENCY, ST_DATA, ST_ROW, ST_DONE
    } mpbi_state_e;

endpackage : mpbi_pkg

/* src/mpbi_device.sv */
// How it works
// - Bus configuration mode bit one gives asynchronous bus, zero gives burst bus.
// - In async write, write enable overrides output enable; output enable high during address.
// - Async write data captured on first rising chip select, write enable or, for array writes only, byte enable.
// - WAIT driven during async reads, floated during async writes and standby; host ignores it.
// - Burst address latched on first clock rise with address valid low; WE picks direction.
// - Fixed bursts of 4, 8, 16 or 32 words, or continuous, per configuration.
// - Continuous burst runs to last address, wraps to first and continues.
// - Configured latency count elapses before first word; writes always use fixed latency.
// - Variable latency needs WAIT watching; fixed latency covers worst case.
// - WAIT asserted at burst start, released when data moves.
// - WAIT reasserted at row boundary unless wrapping; next row opened, burst continues.
// - Self initialization lasts 150 us after power-up; host keeps select high.
// - Select rising after refresh register bit 4 cleared enters deep power-down.
// - Both byte enables low drive all 16 bits; otherwise only the enabled byte.
// - Select high means standby: bus and WAIT float, inputs isolated.
// - Bus carries address while address valid low, data while it is high.
// - Register select high steers accesses to configuration registers, not the array.
// - Address bits 19:18 pick bus config, refresh config or identification register.
module mpbi_device #(
    parameter logic [15:0] DEVICE_IDENT = 16'h5A3C  // Arbitrary value
) (
    input logic clk,
    input logic resetn,
    input logic clkEn,
    input mpbi_pkg::mpbi_pins_s pinsIn,
    output logic [15:0] dqOut,
    output logic [1:0] dqOe,
    output logic waitOut,
    output logic waitOe,
    output logic deepPowerdown,
    output logic initBusy
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Words in a fixed burst, zero for continuous
    function automatic logic [5:0] burstWords(input logic [2:0] code);
        case (code)
            mpbi_pkg::LEN_4: burstWords = 6'h04;
            mpbi_pkg::LEN_8: burstWords = 6'h08;
            mpbi_pkg::LEN_16: burstWords = 6'h10;
            mpbi_pkg::LEN_32: burstWords = 6'h20;
            default: burstWords = 6'h00;
        endcase
    endfunction : burstWords

    // Only enabled byte lanes reach the array
    function automatic logic [15:0] mergeBytes(input logic [15:0] oldW, input logic [15:0] newW,
                                               input logic lbN, input logic ubN);
        mergeBytes = {ubN ? oldW[15:8] : newW[15:8], lbN ? oldW[7:0] : newW[7:0]};
    endfunction : mergeBytes

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once the second and third stage agree

    mpbi_pkg::mpbi_pins_s syncA_reg, syncB_reg, syncC_reg, filt_reg, prev_reg, filt_next;
    logic [mpbi_pkg::DATA_W-1:0] mem [0:(1 << mpbi_pkg::ADDR_W)-1];

    always_comb begin
        filt_next = (~(syncB_reg ^ syncC_reg) & syncC_reg) | ((syncB_reg ^ syncC_reg) & filt_reg);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA_reg <= mpbi_pkg::PINS_IDLE;
            syncB_reg <= mpbi_pkg::PINS_IDLE;
            syncC_reg <= mpbi_pkg::PINS_IDLE;
            filt_reg <= mpbi_pkg::PINS_IDLE;
            prev_reg <= mpbi_pkg::PINS_IDLE;
        end else if (clkEn) begin
            syncA_reg <= pinsIn;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            filt_reg <= filt_next;
            prev_reg <= filt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection on filtered pins

    logic ceRise, ceFall, advRise, clkRise, weRise, lbRise, ubRise;
    assign ceRise = filt_reg.ceN & ~prev_reg.ceN;
    assign ceFall = ~filt_reg.ceN & prev_reg.ceN;
    assign advRise = filt_reg.addrValidN & ~prev_reg.addrValidN;
    assign clkRise = filt_reg.memClk & ~prev_reg.memClk;
    assign weRise = filt_reg.weN & ~prev_reg.weN;
    assign lbRise = filt_reg.lowByteEnN & ~prev_reg.lowByteEnN;
    assign ubRise = filt_reg.highByteEnN & ~prev_reg.highByteEnN;

    ////////////////////////////////////////////////////////////////////////////////
    // Control state

    mpbi_pkg::mpbi_state_e state_reg, state_next;
    logic [10:0] initCnt_reg, initCnt_next;
    logic [21:0] addr_reg, addr_next;
    logic [3:0] latCnt_reg, latCnt_next;
    logic [3:0] rowCnt_reg, rowCnt_next;
    logic [5:0] wordCnt_reg, wordCnt_next;
    logic isWrite_reg, isWrite_next;
    logic cre_reg, cre_next;
    logic asyncValid_reg, asyncValid_next;
    logic wrDone_reg, wrDone_next;
    logic [15:0] bcr_reg, bcr_next, rcr_reg, rcr_next;
    logic [15:0] dqOut_next;
    logic [1:0] dqOe_next;
    logic waitOut_next, waitOe_next;
    logic [15:0] dqOut_reg;
    logic [1:0] dqOe_reg;
    logic waitOut_reg, waitOe_reg, deepPd_reg, deepPd_next, initBusy_reg, initBusy_next;

    // Working signals
    logic asyncMode, wrapOn, readDrive, asyncWrEv, rowCross, regWr, memWe;
    logic [5:0] lenWords;
    logic [4:0] lenMask;
    logic [21:0] latchAddr, regWAddr, nextAddr, incAddr;
    logic [15:0] regWord, rdArray, rdWord, wrData, memWData;
    logic [2:0] latCode;
    logic wrLbN, wrUbN;

    // Configuration decode and read mux
    always_comb begin
        asyncMode = bcr_reg[mpbi_pkg::BCR_MODE_BIT];
        lenWords = burstWords(bcr_reg[mpbi_pkg::BCR_LEN_HI:mpbi_pkg::BCR_LEN_LO]);
        wrapOn = bcr_reg[mpbi_pkg::BCR_WRAP_BIT] && (lenWords != 6'h00);
        lenMask = 5'(lenWords - 6'h01);
        latCode = bcr_reg[mpbi_pkg::BCR_LAT_HI:mpbi_pkg::BCR_LAT_LO];
        latchAddr = {filt_reg.addrHigh, filt_reg.dq};
        incAddr = addr_reg + 22'h000001;  // Natural overflow wraps to zero
        nextAddr = wrapOn ? {addr_reg[21:5], (addr_reg[4:0] & ~lenMask) | (incAddr[4:0] & lenMask)} : incAddr;
        rowCross = !wrapOn && (nextAddr[mpbi_pkg::ROW_BITS-1:0] == mpbi_pkg::ROW_START);
        case (addr_reg[mpbi_pkg::REG_SEL_HI:mpbi_pkg::REG_SEL_LO])
            mpbi_pkg::REG_SEL_BCR: regWord = bcr_reg;
            mpbi_pkg::REG_SEL_RCR: regWord = rcr_reg;
            mpbi_pkg::REG_SEL_IDENT: regWord = DEVICE_IDENT;
            default: regWord = 16'h0000;
        endcase
        rdArray = mem[addr_reg];
        rdWord = cre_reg ? regWord : rdArray;
    end

    // Async read drives only when write enable is high, so a write always wins
    assign readDrive = (state_reg == mpbi_pkg::ST_ACTIVE) && asyncValid_reg && !filt_reg.ceN
                       && filt_reg.addrValidN && !filt_reg.oeN && filt_reg.weN;
    // First rising strobe while write enable was low ends the write
    assign asyncWrEv = (state_reg == mpbi_pkg::ST_ACTIVE) && asyncValid_reg && !wrDone_reg
                       && !prev_reg.weN && (ceRise || weRise || (!cre_reg && (lbRise || ubRise)));

    // Main sequencer
    always_comb begin
        state_next = state_reg;
        initCnt_next = initCnt_reg;
        addr_next = addr_reg;
        latCnt_next = latCnt_reg;
        rowCnt_next = rowCnt_reg;
        wordCnt_next = wordCnt_reg;
        isWrite_next = isWrite_reg;
        cre_next = cre_reg;
        asyncValid_next = asyncValid_reg;
        wrDone_next = wrDone_reg;
        bcr_next = bcr_reg;
        rcr_next = rcr_reg;
        dqOut_next = dqOut_reg;
        dqOe_next = 2'h0;
        waitOut_next = 1'b0;
        waitOe_next = 1'b0;
        regWr = 1'b0;
        regWAddr = addr_reg;
        memWe = 1'b0;
        wrData = filt_reg.dq;
        wrLbN = filt_reg.lowByteEnN;
        wrUbN = filt_reg.highByteEnN;
        case (state_reg)
            mpbi_pkg::ST_INIT: begin
                // Bus is ignored and floated until the init count reaches INIT_LAST
                if (initCnt_reg == mpbi_pkg::INIT_LAST) begin
                    state_next = mpbi_pkg::ST_STANDBY;
                end else begin
                    initCnt_next = initCnt_reg + 11'h001;
                end
            end
            mpbi_pkg::ST_STANDBY: begin
                if (!filt_reg.ceN) begin
                    state_next = mpbi_pkg::ST_ACTIVE;
                    asyncValid_next = 1'b0;
                    wrDone_next = 1'b0;
                end
            end
            mpbi_pkg::ST_DPD: begin
                // Leaving deep power-down repeats the full self initialization
                if (ceFall) begin
                    state_next = mpbi_pkg::ST_INIT;
                    initCnt_next = 11'h000;
                end
            end
            mpbi_pkg::ST_ACTIVE: begin
                if (advRise) begin
                    addr_next = {prev_reg.addrHigh, prev_reg.dq};
                    cre_next = prev_reg.cfgRegSelect;
                    asyncValid_next = 1'b1;
                    wrDone_next = 1'b0;
                end
                if (readDrive) begin
                    dqOut_next = rdWord;
                    dqOe_next = {~filt_reg.highByteEnN, ~filt_reg.lowByteEnN};
                    waitOe_next = 1'b1;
                end
                if (asyncWrEv) begin
                    wrDone_next = 1'b1;
                    regWr = cre_reg;
                    memWe = !cre_reg;
                    wrData = prev_reg.dq;
                    wrLbN = prev_reg.lowByteEnN;
                    wrUbN = prev_reg.highByteEnN;
                end
                if (!asyncMode && clkRise && !filt_reg.addrValidN) begin
                    state_next = mpbi_pkg::ST_LATENCY;
                    addr_next = latchAddr;
                    isWrite_next = !filt_reg.weN;
                    cre_next = filt_reg.cfgRegSelect;
                    wordCnt_next = 6'h00;
                    regWr = filt_reg.cfgRegSelect && !filt_reg.weN;
                    regWAddr = latchAddr;
                    // No refresh is modelled, so variable latency never stretches; fixed pays worst case
                    if (!filt_reg.weN || bcr_reg[mpbi_pkg::BCR_FIXED_LAT_BIT]) begin
                        latCnt_next = {latCode, 1'b0};
                    end else begin
                        latCnt_next = {1'b0, latCode};
                    end
                    if (latCode == 3'h0) begin
                        latCnt_next = 4'h1;
                    end
                end
            end
            mpbi_pkg::ST_LATENCY: begin
                waitOe_next = 1'b1;
                waitOut_next = 1'b1;
                if (clkRise) begin
                    if (latCnt_reg <= 4'h1) begin
                        state_next = mpbi_pkg::ST_DATA;
                        waitOut_next = 1'b0;
                    end else begin
                        latCnt_next = latCnt_reg - 4'h1;
                    end
                end
            end
            mpbi_pkg::ST_DATA: begin
                waitOe_next = 1'b1;
                if (!isWrite_reg) begin
                    dqOut_next = rdWord;
                    dqOe_next = {~filt_reg.highByteEnN, ~filt_reg.lowByteEnN};
                end
                if (clkRise) begin
                    memWe = isWrite_reg && !cre_reg;
                    wordCnt_next = wordCnt_reg + 6'h01;
                    addr_next = nextAddr;
                    if (cre_reg || (lenWords != 6'h00 && !wrapOn && wordCnt_next == lenWords)) begin
                        state_next = mpbi_pkg::ST_DONE;
                    end else if (rowCross) begin
                        state_next = mpbi_pkg::ST_ROW;
                        rowCnt_next = mpbi_pkg::ROW_REOPEN_CYCLES;
                        waitOut_next = 1'b1;
                    end
                end
            end
            mpbi_pkg::ST_ROW: begin
                // Old row restored and next one opened while WAIT holds the host
                waitOe_next = 1'b1;
                waitOut_next = 1'b1;
                if (clkRise) begin
                    rowCnt_next = rowCnt_reg - 4'h1;
                    if (rowCnt_reg <= 4'h1) begin
                        state_next = mpbi_pkg::ST_DATA;
                        waitOut_next = 1'b0;
                    end
                end
            end
            mpbi_pkg::ST_DONE: begin
                waitOe_next = 1'b1;
            end
            default: begin
                state_next = mpbi_pkg::ST_INIT;
                initCnt_next = 11'h000;
            end
        endcase
        // Select rising ends any active cycle, possibly into deep power-down
        if (ceRise && state_reg != mpbi_pkg::ST_INIT && state_reg != mpbi_pkg::ST_DPD) begin
            state_next = rcr_reg[mpbi_pkg::RCR_DPD_BIT] ? mpbi_pkg::ST_STANDBY : mpbi_pkg::ST_DPD;
            dqOe_next = 2'h0;
            waitOe_next = 1'b0;
        end
        if (regWr) begin
            case (regWAddr[mpbi_pkg::REG_SEL_HI:mpbi_pkg::REG_SEL_LO])
                mpbi_pkg::REG_SEL_BCR: bcr_next = regWAddr[15:0];
                mpbi_pkg::REG_SEL_RCR: rcr_next = regWAddr[15:0];
                default: bcr_next = bcr_reg;
            endcase
        end
        memWData = mergeBytes(rdArray, wrData, wrLbN, wrUbN);
        // Status pins come from flops, so they follow the state register exactly
        deepPd_next = (state_next == mpbi_pkg::ST_DPD);
        initBusy_next = (state_next == mpbi_pkg::ST_INIT);
    end

    // State registers; clkEn low freezes everything
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= mpbi_pkg::ST_INIT;
            initCnt_reg <= 11'h000;
            addr_reg <= 22'h000000;
            latCnt_reg <= 4'h0;
            rowCnt_reg <= 4'h0;
            wordCnt_reg <= 6'h00;
            isWrite_reg <= 1'b0;
            cre_reg <= 1'b0;
            asyncValid_reg <= 1'b0;
            wrDone_reg <= 1'b0;
            bcr_reg <= mpbi_pkg::BCR_RESET;
            rcr_reg <= mpbi_pkg::RCR_RESET;
            dqOut_reg <= 16'h0000;
            dqOe_reg <= 2'h0;
            waitOut_reg <= 1'b0;
            waitOe_reg <= 1'b0;
            deepPd_reg <= 1'b0;
            initBusy_reg <= 1'b1;
        end else if (clkEn) begin
            state_reg <= state_next;
            initCnt_reg <= initCnt_next;
            addr_reg <= addr_next;
            latCnt_reg <= latCnt_next;
            rowCnt_reg <= rowCnt_next;
            wordCnt_reg <= wordCnt_next;
            isWrite_reg <= isWrite_next;
            cre_reg <= cre_next;
            asyncValid_reg <= asyncValid_next;
            wrDone_reg <= wrDone_next;
            bcr_reg <= bcr_next;
            rcr_reg <= rcr_next;
            dqOut_reg <= dqOut_next;
            dqOe_reg <= dqOe_next;
            waitOut_reg <= waitOut_next;
            waitOe_reg <= waitOe_next;
            deepPd_reg <= deepPd_next;
            initBusy_reg <= initBusy_next;
        end
    end

    // Array has no reset; contents are undefined after power-up
    always_ff @(posedge clk) begin
        if (clkEn && memWe) begin
            mem[addr_reg] <= memWData;
        end
    end

    assign dqOut = dqOut_reg;
    assign dqOe = dqOe_reg;
    assign waitOut = waitOut_reg;
    assign waitOe = waitOe_reg;
    assign deepPowerdown = deepPd_reg;
    assign initBusy = initBusy_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !clkEn);

    sequence burstLatch;
        state_reg == mpbi_pkg::ST_ACTIVE && !asyncMode && clkRise && !filt_reg.addrValidN && !ceRise;
    endsequence
    sequence rowEnter;
        state_reg == mpbi_pkg::ST_DATA && clkRise && rowCross && !ceRise && state_next == mpbi_pkg::ST_ROW;
    endsequence

    async_no_burst_a: assert property (state_reg == mpbi_pkg::ST_ACTIVE && asyncMode && clkRise && !ceRise
        |=> state_reg == mpbi_pkg::ST_ACTIVE) else $error("burst started in async mode");
    burst_latch_a: assert property (burstLatch |=> state_reg == mpbi_pkg::ST_LATENCY
        && addr_reg == $past(latchAddr) && isWrite_reg == !$past(filt_reg.weN)) else $error("bad burst latch");
    latency_wait_a: assert property (burstLatch ##1 (state_reg == mpbi_pkg::ST_LATENCY)[*2]
        |-> waitOut_reg && waitOe_reg) else $error("WAIT low during latency");
    row_wait_a: assert property (rowEnter |=> state_reg == mpbi_pkg::ST_ROW ##0 waitOut_reg)
        else $error("no WAIT at row boundary");
    standby_float_a: assert property (state_reg == mpbi_pkg::ST_STANDBY && $past(state_reg) == mpbi_pkg::ST_STANDBY
        |-> dqOe_reg == 2'h0 && !waitOe_reg) else $error("pins driven in standby");
    dpd_entry_a: assert property (state_reg == mpbi_pkg::ST_ACTIVE && ceRise && !rcr_reg[mpbi_pkg::RCR_DPD_BIT]
        |=> state_reg == mpbi_pkg::ST_DPD) else $error("deep power-down not entered");
    init_end_a: assert property (state_reg == mpbi_pkg::ST_INIT
        |=> (state_reg == mpbi_pkg::ST_STANDBY) == ($past(initCnt_reg) == mpbi_pkg::INIT_LAST))
        else $error("init length wrong");
    byte_lane_a: assert property (readDrive && !ceRise
        |=> dqOe_reg == ~{$past(filt_reg.highByteEnN), $past(filt_reg.lowByteEnN)})
        else $error("wrong byte lanes driven");
    async_wait_a: assert property (readDrive && !ceRise |=> waitOe_reg && !waitOut_reg)
        else $error("WAIT not driven on async read");
    burst_len_a: assert property (state_reg == mpbi_pkg::ST_DATA && clkRise && !ceRise && !cre_reg && !wrapOn
        && lenWords != 6'h00 && wordCnt_reg == lenWords - 6'h01 |=> state_reg == mpbi_pkg::ST_DONE)
        else $error("fixed burst did not stop");

endmodule : mpbi_device

/* verif/mpbi_host_model.sv */
// Behavioural host controller facing the device pins
module mpbi_host_model (
    input logic clk,
    output mpbi_pkg::mpbi_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pins = mpbi_pkg::PINS_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin bundle builder, ctl = {ceN, addrValidN, oeN, weN}, beN = {highByteEnN, lowByteEnN}
    function automatic mpbi_pkg::mpbi_pins_s mk(input logic [3:0] ctl, input logic [1:0] beN, input logic cfg_reg_select,
            input logic mclk, input logic [21:0] ad);
        return '{ctl[3], ctl[2], ctl[1], ctl[0], beN[0], beN[1], cfg_reg_select, mclk, ad[21:16], ad[15:0]};
    endfunction : mk

    // Each level holds at least 9 cycles, over twice the input filter depth, so pin order is never lost
    task automatic drive(input mpbi_pkg::mpbi_pins_s p);
        @(posedge clk);
        pins <= p;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : drive

    ////////////////////////////////////////////////////////////////////////////////
    // Async write: address phase with oeN high, latch, data, weN rise, deselect
    task automatic write_word(input logic [21:0] addr, input logic [15:0] data, input logic cfg_reg_select, input logic [1:0] beN);
        drive(mk(4'h2, beN, cfg_reg_select, 1'b0, addr));
        drive(mk(4'h6, beN, cfg_reg_select, 1'b0, addr));
        drive(mk(4'h6, beN, cfg_reg_select, 1'b0, {addr[21:16], data}));
        drive(mk(4'h7, beN, cfg_reg_select, 1'b0, {addr[21:16], data}));
        drive(mk(4'hF, 2'h3, 1'b0, 1'b0, {addr[21:16], ~data}));
    endtask : write_word

    // Async read, left with oeN low; the released bus shows the inverse so stale values never match
    task automatic read_word(input logic [21:0] addr, input logic cfg_reg_select, input logic [1:0] beN);
        drive(mk(4'h3, beN, cfg_reg_select, 1'b0, addr));
        drive(mk(4'h7, beN, cfg_reg_select, 1'b0, ~addr));
        drive(mk(4'h5, beN, cfg_reg_select, 1'b0, ~addr));
    endtask : read_word

    // Deselect with the burst clock parked low for standby
    task automatic finish_read();
        drive(mk(4'hF, 2'h3, 1'b0, 1'b0, 22'h000000));
    endtask : finish_read

    // Burst setup: address on bus, oeN low, clock still low
    task automatic burst_start(input logic [21:0] addr);
        drive(mk(4'h1, 2'h0, 1'b0, 1'b0, addr));
    endtask : burst_start

    // One burst clock period; addrValidN rises after the first rise
    task automatic tick();
        mpbi_pkg::mpbi_pins_s p;
        p = pins;
        p.memClk = 1'b1;
        drive(p);
        p.memClk = 1'b0;
        p.addrValidN = 1'b1;
        p.dq = ~p.dq;
        drive(p);
    endtask : tick
endmodule : mpbi_host_model

/* verif/test_mpbi_device.sv */
`define CHK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin errTotal++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end

module test_mpbi_device;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    mpbi_pkg::mpbi_pins_s pins;
    logic [15:0] dqOut;
    logic [1:0] dqOe;
    logic waitOut, waitOe, deepPowerdown, initBusy;
    int errTotal = 0;
    int nCompared = 0;
    int cycles = 0;
    logic [15:0] mem [4];

    // 100 ns clock
    always #50 clk = ~clk;

    mpbi_host_model HOST (.clk(clk), .pins(pins));
    mpbi_device DUT (.clk(clk), .resetn(resetn), .clkEn(1'b1), .pinsIn(pins), .dqOut(dqOut), .dqOe(dqOe),
        .waitOut(waitOut), .waitOe(waitOe), .deepPowerdown(deepPowerdown), .initBusy(initBusy));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // Whole run needs about 2300 cycles; a hang is cut well after that
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errTotal++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self initialization lasts 1500 cycles; host keeps select high meanwhile
    task automatic test_init();
        int n;
        n = 0;
        `CHK("initBusy", 1'b1, initBusy)
        while (initBusy !== 1'b0 && n < 1600) begin
            @(negedge clk);
            n++;
        end
        `CHK("init length", 1'b1, (n >= 1495 && n <= 1505))
    endtask : test_init

    // Full and partial writes, then reads on both lanes and standby release
    task automatic test_async();
        for (int i = 0; i < 4; i++) begin
            mem[i] = 16'hA5C0 + 16'(i);
            HOST.write_word(22'h000010 + 22'(i), mem[i], 1'b0, 2'h0);
        end
        HOST.write_word(22'h000010, 16'h3C3C, 1'b0, 2'h2);
        mem[0][7:0] = 8'h3C;
        for (int i = 0; i < 4; i++) begin
            HOST.read_word(22'h000010 + 22'(i), 1'b0, 2'h0);
            `CHK("dqOe", 2'h3, dqOe)
            `CHK("dqOut", mem[i], dqOut)
            `CHK("waitOe read", 1'b1, waitOe)
            HOST.finish_read();
            `CHK("dqOe standby", 2'h0, dqOe)
            `CHK("waitOe standby", 1'b0, waitOe)
        end
        HOST.read_word(22'h000010, 1'b0, 2'h1);
        `CHK("dqOe upper", 2'h2, dqOe)
        `CHK("dqOut upper", mem[0][15:8], dqOut[15:8])
        HOST.finish_read();
    endtask : test_async

    // Burst mode, variable latency 2, four-word read
    task automatic test_burst();
        HOST.write_word({6'h08, 16'h1001}, 16'h0000, 1'b1, 2'h0);
        HOST.burst_start(22'h000010);
        HOST.tick();
        `CHK("waitOe burst", 1'b1, waitOe)
        `CHK("waitOut start", 1'b1, waitOut)
        HOST.tick();
        `CHK("waitOut latency", 1'b1, waitOut)
        for (int i = 0; i < 4; i++) begin
            HOST.tick();
            `CHK("waitOut data", 1'b0, waitOut)
            `CHK("burst word", mem[i], dqOut)
        end
        HOST.finish_read();
        `CHK("dqOe after burst", 2'h0, dqOe)
    endtask : test_burst

    // Burst write of the bus register back to async, then register reads
    task automatic test_cfg_burst();
        HOST.drive(HOST.mk(4'h2, 2'h0, 1'b1, 1'b0, {6'h08, 16'h9807}));
        repeat (6) HOST.tick();
        `CHK("waitOut cfg done", 1'b0, waitOut)
        HOST.finish_read();
        HOST.read_word({6'h08, 16'h0000}, 1'b1, 2'h0);
        `CHK("bus config", 16'h9807, dqOut)
        HOST.finish_read();
        HOST.read_word({6'h04, 16'h0000}, 1'b1, 2'h0);
        `CHK("ident", 16'h5A3C, dqOut)
        HOST.finish_read();
    endtask : test_cfg_burst

    // Clearing refresh bit 4 then deselecting enters deep power-down
    task automatic test_dpd();
        HOST.write_word({6'h00, 16'h0000}, 16'h0000, 1'b1, 2'h0);
        `CHK("deepPowerdown", 1'b1, deepPowerdown)
        HOST.drive(HOST.mk(4'h7, 2'h3, 1'b0, 1'b0, 22'h000000));
        `CHK("deepPowerdown exit", 1'b0, deepPowerdown)
        `CHK("initBusy again", 1'b1, initBusy)
    endtask : test_dpd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        test_init();
        test_async();
        test_burst();
        test_cfg_burst();
        test_dpd();
        results();
    end
endmodule : test_mpbi_device
